// File: hdl/ana_adv_reg.sv
// auto-negotiation advertisement register with restart-gated page
`timescale 1ns/1ps
`default_nettype none
`include "ana_consts.svh"
module ana_adv_reg
  import ana_pkg::*;
#(
  parameter int ADDR_W = `ANA_ADDR_W
)
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic NEG_RESTART,
  output logic [15:0] ADV_PAGE,
  output logic ADV_PENDING
);

  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic ana_hit(input logic [ADDR_W-1:0] a);
    ana_hit = (a == ADDR_W'(`ANA_ADV_OFFSET));
  endfunction

  // builds the visible word from the writable state
  function automatic ana_adv_t ana_word(input logic rf, input logic [3:0] ab);
    ana_adv_t w;
    w = '0;
    w.next_page_capable = `ANA_NP_VALUE;
    w.remote_fault_advert = rf;
    w.ability_100tx_full = ab[3];
    w.ability_100tx_half = ab[2];
    w.ability_10t_full = ab[1];
    w.ability_10t_half = ab[0];
    w.selector = `ANA_SEL_IEEE8023;
    ana_word = w;
  endfunction

  // ********************************************************************
  // write decode
  // ********************************************************************
  localparam logic [3:0] ABIL_RESET = `ANA_ABIL_RESET;

  logic wr_hit;

  // writes to other offsets and to the read-only fields never land
  assign wr_hit = WR && ana_hit(ADDR);

  // ********************************************************************
  // remote fault advertisement
  // ********************************************************************
  logic remote_fault_advert;
  logic next_remote_fault_advert;

  always_comb begin
    next_remote_fault_advert = remote_fault_advert;
    if (wr_hit) begin
      next_remote_fault_advert = WDATA[`ANA_REMOTE_FAULT_BIT];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      remote_fault_advert <= `ANA_RF_RESET;
    end else begin
      remote_fault_advert <= next_remote_fault_advert;
    end
  end

  // ********************************************************************
  // ability: 100tx full duplex
  // ********************************************************************
  logic ability_100tx_full;
  logic next_ability_100tx_full;

  always_comb begin
    next_ability_100tx_full = ability_100tx_full;
    if (wr_hit) begin
      next_ability_100tx_full = WDATA[`ANA_ABIL_LSB + 3];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ability_100tx_full <= ABIL_RESET[3];
    end else begin
      ability_100tx_full <= next_ability_100tx_full;
    end
  end

  // ********************************************************************
  // ability: 100tx half duplex
  // ********************************************************************
  logic ability_100tx_half;
  logic next_ability_100tx_half;

  always_comb begin
    next_ability_100tx_half = ability_100tx_half;
    if (wr_hit) begin
      next_ability_100tx_half = WDATA[`ANA_ABIL_LSB + 2];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ability_100tx_half <= ABIL_RESET[2];
    end else begin
      ability_100tx_half <= next_ability_100tx_half;
    end
  end

  // ********************************************************************
  // ability: 10t full duplex
  // ********************************************************************
  logic ability_10t_full;
  logic next_ability_10t_full;

  always_comb begin
    next_ability_10t_full = ability_10t_full;
    if (wr_hit) begin
      next_ability_10t_full = WDATA[`ANA_ABIL_LSB + 1];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ability_10t_full <= ABIL_RESET[1];
    end else begin
      ability_10t_full <= next_ability_10t_full;
    end
  end

  // ********************************************************************
  // ability: 10t half duplex
  // ********************************************************************
  logic ability_10t_half;
  logic next_ability_10t_half;

  always_comb begin
    next_ability_10t_half = ability_10t_half;
    if (wr_hit) begin
      next_ability_10t_half = WDATA[`ANA_ABIL_LSB];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ability_10t_half <= ABIL_RESET[0];
    end else begin
      ability_10t_half <= next_ability_10t_half;
    end
  end

  // ********************************************************************
  // read port
  // ********************************************************************
  logic [3:0] abilities;
  logic [3:0] next_abilities;
  ana_adv_t cur_word;
  logic [15:0] next_rdata;

  // ability order on the page, highest bit first
  assign abilities = {ability_100tx_full, ability_100tx_half, ability_10t_full, ability_10t_half};
  assign next_abilities = {next_ability_100tx_full, next_ability_100tx_half,
    next_ability_10t_full, next_ability_10t_half};
  assign cur_word = ana_word(remote_fault_advert, abilities);

  always_comb begin
    next_rdata = 16'h0000;
    if (RD && ana_hit(ADDR)) begin
      next_rdata = cur_word;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // ********************************************************************
  // pending tracker: contents written but not yet on the line
  // ********************************************************************
  ana_state_t state;
  ana_state_t next_state;
  logic next_adv_pending;

  always_comb begin
    next_state = state;
    unique case (state)
      ANA_IN_USE: begin
        if (wr_hit && !NEG_RESTART) begin
          next_state = ANA_PENDING;
        end
      end
      ANA_PENDING: begin
        if (NEG_RESTART) begin
          next_state = ANA_IN_USE;
        end
      end
      default: begin
        next_state = ANA_IN_USE;
      end
    endcase
    next_adv_pending = (next_state == ANA_PENDING);
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= ANA_IN_USE;
      ADV_PENDING <= 1'b0;
    end else begin
      state <= next_state;
      ADV_PENDING <= next_adv_pending;
    end
  end

  // ********************************************************************
  // page latch
  // ********************************************************************
  ana_adv_if adv ();

  assign adv.next_word = ana_word(next_remote_fault_advert, next_abilities);
  assign adv.restart = NEG_RESTART;
  assign ADV_PAGE = adv.page;

  ana_page_latch u_latch (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .adv(adv.latch_side)
  );

endmodule
`default_nettype wire

// File: hdl/ana_consts.svh
// constants for the auto-negotiation advertisement register
//
// How it works
// - abilities held writable in bits 8:5
// - new contents used only after negotiation restart
// - reset value reads 0x01e1
// - selector bits 4:0 fixed 0x01, writes ignored
// - five-bit selector, only one value advertised
// - bit 13 writable remote fault, reset 0
`ifndef ANA_CONSTS_SVH
`define ANA_CONSTS_SVH

// ********************************************************************
// register map
// ********************************************************************
`define ANA_ADDR_W 5
`define ANA_ADV_OFFSET 5'h04
`define ANA_DATA_W 16

// ********************************************************************
// field positions and values
// ********************************************************************
`define ANA_NEXT_PAGE_BIT 15
`define ANA_REMOTE_FAULT_BIT 13
`define ANA_ABIL_MSB 8
`define ANA_ABIL_LSB 5
`define ANA_SEL_MSB 4
`define ANA_SEL_LSB 0
`define ANA_SEL_IEEE8023 5'h01
`define ANA_ABIL_RESET 4'hf
`define ANA_RF_RESET 1'b0
`define ANA_NP_VALUE 1'b0
`define ANA_ADV_RESET 16'h01e1
`define ANA_ADV_WMASK 16'h21e0

`endif

// File: hdl/ana_pkg.sv
// types for the auto-negotiation advertisement register
package ana_pkg;

  typedef struct packed {
    logic next_page_capable;
    logic rsvd14;
    logic remote_fault_advert;
    logic [3:0] rsvd12_9;
    logic ability_100tx_full;
    logic ability_100tx_half;
    logic ability_10t_full;
    logic ability_10t_half;
    logic [4:0] selector;
  } ana_adv_t;

  typedef enum logic [1:0] {
    ANA_IN_USE = 2'b00,
    ANA_PENDING = 2'b01
  } ana_state_t;

endpackage

// File: hdl/ana_adv_if.sv
// carrier between the register and the page latch
`timescale 1ns/1ps
`default_nettype none
interface ana_adv_if;
  import ana_pkg::*;
  ana_adv_t next_word;
  logic restart;
  ana_adv_t page;

  modport reg_side (output next_word, output restart, input page);
  modport latch_side (input next_word, input restart, output page);
endinterface
`default_nettype wire

// File: hdl/ana_page_latch.sv
// page in use on the line, taken from the register at restart
`timescale 1ns/1ps
`default_nettype none
`include "ana_consts.svh"
module ana_page_latch
  import ana_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ana_adv_if.latch_side adv
);

  ana_adv_t page;
  ana_adv_t next_page;

  // ********************************************************************
  // capture at restart only
  // ********************************************************************
  always_comb begin
    next_page = page;
    if (adv.restart) begin
      next_page = adv.next_word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page <= `ANA_ADV_RESET;
    end else begin
      page <= next_page;
    end
  end

  assign adv.page = page;

endmodule
`default_nettype wire

// File: hdl/ana_adv_reg_end.sv
// end marker file intentionally holds only a timescale-free comment

// File: sim/ana_adv_reg_asserts.sv
// assertion checker for the advertisement register
`timescale 1ns/1ps
`default_nettype none
module ana_adv_reg_asserts #(parameter int ADDR_W = 5) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic NEG_RESTART,
  input wire logic [15:0] ADV_PAGE,
  input wire logic ADV_PENDING
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_wr;
    WR && ADDR == 5'h04;
  endsequence
  sequence s_wr_rd;
    s_wr ##1 (RD && ADDR == 5'h04);
  endsequence
  a_abil_write: assert property (s_wr_rd |=> RDATA[8:5] == $past(WDATA[8:5], 2))
    else $error("ability bits not written");
  a_fault_write: assert property (s_wr_rd |=> RDATA[13] == $past(WDATA[13], 2))
    else $error("remote fault bit not written");
  a_sel_read: assert property (RD && ADDR == 5'h04 |=> RDATA[4:0] == 5'h01)
    else $error("selector not fixed");
  a_rsvd_zero: assert property (RD |=> RDATA[15:14] == 0 && RDATA[12:9] == 0)
    else $error("read-only zero bits set");
  a_page_hold: assert property (!NEG_RESTART |=> $stable(ADV_PAGE))
    else $error("page changed without restart");
  a_page_load: assert property (s_wr ##1 (NEG_RESTART && !WR) |=>
    (ADV_PAGE & 16'h21e0) == ($past(WDATA, 2) & 16'h21e0))
    else $error("page not loaded at restart");
  a_pend_set: assert property (WR && ADDR == 5'h04 && !NEG_RESTART |=> ADV_PENDING)
    else $error("pending not set by write");
  a_pend_clear: assert property (NEG_RESTART |=> !ADV_PENDING)
    else $error("pending not cleared by restart");
  a_rdata_idle: assert property (!RD |=> RDATA == 0)
    else $error("read data outside read cycle");
endmodule
bind ana_adv_reg ana_adv_reg_asserts #(.ADDR_W(ADDR_W)) u_chk (.CORE_CLK(CORE_CLK),
  .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .NEG_RESTART(NEG_RESTART), .ADV_PAGE(ADV_PAGE), .ADV_PENDING(ADV_PENDING));
`default_nettype wire

// File: sim/ana_adv_reg_tb.sv
// self-checking bench for the advertisement register
`timescale 1ns/1ps
`default_nettype none
module ana_adv_reg_tb;
  logic CORE_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [4:0] ADDR = 5'h00;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic NEG_RESTART = 1'b0;
  logic [15:0] RDATA;
  logic [15:0] ADV_PAGE;
  logic ADV_PENDING;
  int n_mismatch = 0;
  int checked = 0;
  always #20 CORE_CLK = ~CORE_CLK;
  ana_adv_reg #(.ADDR_W(5)) DUT (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .NEG_RESTART(NEG_RESTART),
    .ADV_PAGE(ADV_PAGE), .ADV_PENDING(ADV_PENDING));
  // ****
  // bus tasks
  // ****
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CORE_CLK);
    WR <= 1'b0;
    #1;
  endtask
  task rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge CORE_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask
  // restart, optionally with a write in the same cycle
  task restart(input logic w, input logic [15:0] d);
    @(posedge CORE_CLK);
    NEG_RESTART <= 1'b1;
    WR <= w;
    ADDR <= 5'h04;
    WDATA <= d;
    @(posedge CORE_CLK);
    NEG_RESTART <= 1'b0;
    WR <= 1'b0;
    #1;
    chk({15'h0, ADV_PENDING}, 16'h0000);
  endtask
  // write, then restart in the very next cycle
  task wr_restart(input logic [15:0] d);
    @(posedge CORE_CLK);
    WR <= 1'b1;
    ADDR <= 5'h04;
    WDATA <= d;
    @(posedge CORE_CLK);
    WR <= 1'b0;
    NEG_RESTART <= 1'b1;
    @(posedge CORE_CLK);
    NEG_RESTART <= 1'b0;
    #1;
    chk({15'h0, ADV_PENDING}, 16'h0000);
  endtask
  // write, then read back in the very next cycle
  task wr_rd(input logic [15:0] d, input logic [15:0] exp);
    @(posedge CORE_CLK);
    WR <= 1'b1;
    ADDR <= 5'h04;
    WDATA <= d;
    @(posedge CORE_CLK);
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask
  task report_and_stop;
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task t_fields;
    wr(5'h04, 16'hffff);
    chk(ADV_PAGE, 16'h01e1);
    chk({15'h0, ADV_PENDING}, 16'h0001);
    rd(5'h04, 16'h21e1);
    restart(1'b0, 16'h0000);
    chk(ADV_PAGE, 16'h21e1);
  endtask
  task t_abil;
    for (int i = 0; i < 4; i++) begin
      wr_restart(16'h01e1 ^ (16'h0020 << i));
      chk(ADV_PAGE, 16'h01e1 ^ (16'h0020 << i));
    end
  endtask
  task t_misc;
    wr(5'h05, 16'h0000);
    rd(5'h05, 16'h0000);
    rd(5'h04, 16'h00e1);
    wr_rd(16'h3f5f, 16'h2141);
    restart(1'b1, 16'h3fff);
    chk(ADV_PAGE, 16'h21e1);
  endtask
  // reset in mid-run brings back the reset word everywhere
  task t_reset;
    wr(5'h04, 16'h2000);
    @(posedge CORE_CLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    #1;
    chk({15'h0, ADV_PENDING}, 16'h0000);
    chk(ADV_PAGE, 16'h01e1);
    rd(5'h04, 16'h01e1);
  endtask
  initial begin
    repeat (12) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    rd(5'h04, 16'h01e1);
    chk(ADV_PAGE, 16'h01e1);
    t_fields;
    t_abil;
    t_misc;
    t_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire
